// file: dpt_drum_timing.sv
// drum bit clock, timing-track decode and circulating lines
`default_nettype none


module dpt_drum_timing
	import dpt_pkg::*;
#(
	parameter int LINES = dpt_pkg::NLINES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// clock track and timing-track heads
	input wire logic i_clk_track,
	input wire logic [dpt_pkg::NTRACKS-1:0] i_track_head,
	// circulating line heads
	input wire logic [LINES-1:0] i_line_head,
	input wire logic [LINES-1:0] i_line_head_alt,
	// mode selects from control
	input wire logic i_mul_div,
	input wire logic i_lengthen,
	// new data for the lines from arithmetic and control
	input wire logic [LINES-1:0] i_line_wr_sel,
	input wire logic [LINES-1:0] i_line_wr_data,
	input wire logic [LINES-1:0] i_line_rec_en,
	// sector request
	input wire logic [dpt_pkg::SECT_W-1:0] i_req_sector,
	// bit clock strobes
	output logic o_clock_toggle,
	output logic o_bit_strobe,
	output logic o_true_phase_strobe,
	output logic o_false_phase_late_strobe,
	output logic o_true_phase_late_strobe,
	output logic o_record_window_strobe,
	// word timing
	output logic [dpt_pkg::NTIMING-1:0] o_timing,
	output logic [dpt_pkg::BIT_W-1:0] o_bit_count,
	output logic [dpt_pkg::SECT_W-1:0] o_sector_count,
	output logic [dpt_pkg::SECT_W-1:0] o_sector_num,
	output logic o_sector_match,
	// line data and head drive
	output logic [LINES-1:0] o_line_early,
	output logic [LINES-1:0] o_line_bit,
	output logic [LINES-1:0] o_line_head_a,
	output logic [LINES-1:0] o_line_head_b
);
	import dpt_pkg::*;

	// refuse parameter values the fixed five-line layout cannot serve
	if (LINES != NLINES) begin : g_bad_lines
		$error("dpt_drum_timing: LINES must equal the five lines");
	end
	if (LATE_CYC >= BIT_CYC / 2 || BIT_CYC >= (1 << PH_W)) begin : g_bad_tim
		$error("dpt_drum_timing: strobe timing does not fit");
	end

	function automatic logic [SECT_W-1:0] sect_next(
		input logic [SECT_W-1:0] s,
		input logic group_end
	);
		logic [SECT_W-1:0] r;
		r = s + 6'h01;
		// an eighth-word mark pulls the count onto a multiple of eight
		if (group_end) begin
			r = {r[SECT_W-1:3], GROUP_MASK};
		end
		return r;
	endfunction

	// ***************************************************************
	// clock track and strobe generation
	// ***************************************************************
	logic [2:0] ck_sync;
	logic toggle, next_toggle;
	logic [PH_W-1:0] ph_cnt, next_ph_cnt;
	logic t1_s, t2_s, t3_s, t4_s, t5_s;
	logic next_t1, next_t2, next_t3, next_t4, next_t5;
	logic rgate, next_rgate;

	// toggle follows the track once stages two and three agree
	always_comb begin
		next_toggle = toggle;
		if (ck_sync[1] == ck_sync[2]) begin
			next_toggle = ck_sync[2];
		end
		next_t1 = 1'b0;
		next_t2 = 1'b0;
		next_t3 = 1'b0;
		next_t4 = 1'b0;
		next_ph_cnt = ph_cnt;
		// counter saturates if the clock track stops
		if (ph_cnt != {PH_W{1'b1}}) begin
			next_ph_cnt = ph_cnt + 8'h01;
		end
		if (next_toggle != toggle) begin
			next_ph_cnt = 8'h00;
			next_t2 = next_toggle;
			next_t1 = ~next_toggle;
		end else if (ph_cnt == 8'(LATE_CYC - 1)) begin
			next_t4 = toggle;
			next_t3 = ~toggle;
		end
		// 2 us window from 1 us into the true half, ends before next cell start
		next_t5 = t5_s;
		if (toggle && next_toggle == toggle) begin
			if (ph_cnt == 8'(RWIN_LEAD_CYC - 1)) begin
				next_t5 = 1'b1;
			end else if (ph_cnt == 8'(RWIN_LEAD_CYC + RWIN_CYC - 1)) begin
				next_t5 = 1'b0;
			end
		end else begin
			next_t5 = 1'b0;
		end
		// heads may drive from cell start until the window closes
		next_rgate = rgate;
		if (next_t1) begin
			next_rgate = 1'b1;
		end else if (t5_s && !next_t5) begin
			next_rgate = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ck_sync <= 3'h0;
			toggle <= 1'b0;
			ph_cnt <= 8'h00;
			t1_s <= 1'b0;
			t2_s <= 1'b0;
			t3_s <= 1'b0;
			t4_s <= 1'b0;
			t5_s <= 1'b0;
			rgate <= 1'b0;
		end else begin
			ck_sync <= {ck_sync[1:0], i_clk_track};
			toggle <= next_toggle;
			ph_cnt <= next_ph_cnt;
			t1_s <= next_t1;
			t2_s <= next_t2;
			t3_s <= next_t3;
			t4_s <= next_t4;
			t5_s <= next_t5;
			rgate <= next_rgate;
		end
	end

	assign o_clock_toggle = toggle;
	assign o_bit_strobe = t1_s;
	assign o_true_phase_strobe = t2_s;
	assign o_false_phase_late_strobe = t3_s;
	assign o_true_phase_late_strobe = t4_s;
	assign o_record_window_strobe = t5_s;

	// ***************************************************************
	// timing tracks: read flop and one-bit delay each
	// ***************************************************************
	logic [NTRACKS-1:0] trk_now, trk_dly;

	for (genvar k = 0; k < NTRACKS; k++) begin : g_trk
		dpt_chan u_trk (
			.i_clk_sys(i_clk_sys),
			.i_rst_n(i_rst_n),
			.i_head(i_track_head[k]),
			.i_head_alt(1'b0),
			.i_use_alt(1'b0),
			.i_bit_stb(t1_s),
			.i_mid_stb(t2_s),
			.i_rec_gate(1'b0),
			.i_rec_bit(1'b0),
			.i_rec_en(1'b0),
			.o_early(trk_now[k]),
			.o_bit(trk_dly[k]),
			.o_head_a(),
			.o_head_b()
		);
	end

	// ***************************************************************
	// word timing decode, counters and sector field
	// ***************************************************************
	logic s1, s2, s3, d2, d3;
	logic [NTIMING-1:0] tim, next_tim;
	logic [BIT_W-1:0] bit_cnt, next_bit_cnt;
	logic [SECT_W-1:0] sec_cnt, next_sec_cnt;
	logic [SECT_W-1:0] sec_shift, next_sec_shift;
	logic [SECT_W-1:0] sec_num, next_sec_num;
	logic match, next_match;
	logic sign_t, eighth_t;

	assign s1 = trk_now[TR_S1];
	assign s2 = trk_now[TR_S2];
	assign s3 = trk_now[TR_S3];
	assign d2 = trk_dly[TR_S2];
	assign d3 = trk_dly[TR_S3];
	assign sign_t = ~d2 & s2;
	assign eighth_t = sign_t & s1;

	// decoded at the late true strobe, when both flops have settled
	always_comb begin
		next_tim = tim;
		next_bit_cnt = bit_cnt;
		next_sec_cnt = sec_cnt;
		next_sec_shift = sec_shift;
		next_sec_num = sec_num;
		next_match = match;
		if (t4_s) begin
			next_tim[0] = ~s2 & s3 & (bit_cnt >= CMD_END);
			next_tim[1] = s2 & s3;
			next_tim[2] = bit_cnt < CMD_END;
			next_tim[3] = bit_cnt == LAST_BIT;
			next_tim[4] = ~s2 & ~s3;
			next_tim[5] = sign_t;
			next_tim[6] = s2 & ~s3;
			next_tim[7] = eighth_t;
			// sign time closes the word; counter wraps at 32
			if (sign_t) begin
				next_bit_cnt = '0;
				next_sec_cnt = sect_next(sec_cnt, eighth_t);
			end else begin
				next_bit_cnt = bit_cnt + 5'h01;
			end
			// sector bits shift in while the third track is false
			if (!s3) begin
				next_sec_shift = {s1, sec_shift[SECT_W-1:1]};
			end else if (!d3) begin
				next_sec_num = sec_shift;
				next_match = sec_shift == i_req_sector;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tim <= '0;
			bit_cnt <= '0;
			sec_cnt <= '0;
			sec_shift <= '0;
			sec_num <= '0;
			match <= 1'b0;
		end else begin
			tim <= next_tim;
			bit_cnt <= next_bit_cnt;
			sec_cnt <= next_sec_cnt;
			sec_shift <= next_sec_shift;
			sec_num <= next_sec_num;
			match <= next_match;
		end
	end

	assign o_timing = tim;
	assign o_bit_count = bit_cnt;
	assign o_sector_count = sec_cnt;
	assign o_sector_num = sec_num;
	assign o_sector_match = match;

	// ***************************************************************
	// circulating lines
	// ***************************************************************
	logic [LINES-1:0] use_alt;
	logic [LINES-1:0] rec_bit;
	logic [LINES-1:0] ln_early, ln_bit;

	// tap choice sets line length; C, X and D have a single tap
	always_comb begin
		use_alt = '0;
		use_alt[LN_U] = i_mul_div;
		use_alt[LN_L] = i_lengthen;
		use_alt[LN_C] = 1'b0;
		use_alt[LN_X] = 1'b0;
		use_alt[LN_D] = 1'b0;
		// recirculate the delayed copy unless control writes new data
		for (int n = 0; n < LINES; n++) begin
			rec_bit[n] = i_line_wr_sel[n] ? i_line_wr_data[n] : ln_bit[n];
		end
	end

	for (genvar n = 0; n < LINES; n++) begin : g_line
		dpt_chan u_line (
			.i_clk_sys(i_clk_sys),
			.i_rst_n(i_rst_n),
			.i_head(i_line_head[n]),
			.i_head_alt(i_line_head_alt[n]),
			.i_use_alt(use_alt[n]),
			.i_bit_stb(t1_s),
			.i_mid_stb(t2_s),
			.i_rec_gate(rgate),
			.i_rec_bit(rec_bit[n]),
			.i_rec_en(i_line_rec_en[n]),
			.o_early(ln_early[n]),
			.o_bit(ln_bit[n]),
			.o_head_a(o_line_head_a[n]),
			.o_head_b(o_line_head_b[n])
		);
	end

	// early tap feeds main memory one bit ahead of the delayed copy
	assign o_line_early = ln_early;
	assign o_line_bit = ln_bit;
endmodule

`default_nettype wire

// file: dpt_chan.sv
// drum head channel: constants package plus one read/record channel
`default_nettype none

package dpt_pkg;
	// ***************************************************************
	// clock and bit-cell timing
	// ***************************************************************
	localparam int CLK_NS = 100;
	localparam int BIT_NS = 8000;
	localparam int LATE_NS = 3000;
	localparam int RWIN_NS = 2000;
	localparam int RWIN_LEAD_NS = 1000;
	localparam int BIT_CYC = BIT_NS / CLK_NS;
	localparam int LATE_CYC = (LATE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RWIN_CYC = RWIN_NS / CLK_NS;
	localparam int RWIN_LEAD_CYC = (RWIN_LEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PH_W = 8;
	// ***************************************************************
	// track layout
	// ***************************************************************
	localparam int SECTORS = 64;
	localparam int BITS = 32;
	localparam int SECT_W = 6;
	localparam int BIT_W = 5;
	localparam int CMD_BITS = 5;
	localparam logic [BIT_W-1:0] LAST_BIT = 5'h1f;
	localparam logic [BIT_W-1:0] CMD_END = 5'h05;
	localparam logic [2:0] GROUP_MASK = 3'h0;
	// ***************************************************************
	// circulating lines and timing tracks
	// ***************************************************************
	localparam int NLINES = 5;
	localparam int LN_U = 0;
	localparam int LN_L = 1;
	localparam int LN_C = 2;
	localparam int LN_X = 3;
	localparam int LN_D = 4;
	localparam int NTRACKS = 3;
	localparam int TR_S1 = 0;
	localparam int TR_S2 = 1;
	localparam int TR_S3 = 2;
	localparam int NTIMING = 8;
endpackage

module dpt_chan (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// head polarity pins, normal and alternate tap
	input wire logic i_head,
	input wire logic i_head_alt,
	input wire logic i_use_alt,
	// strobes from the bit clock
	input wire logic i_bit_stb,
	input wire logic i_mid_stb,
	input wire logic i_rec_gate,
	// record side
	input wire logic i_rec_bit,
	input wire logic i_rec_en,
	// read side
	output logic o_early,
	output logic o_bit,
	// winding drive
	output logic o_head_a,
	output logic o_head_b
);
	logic [2:0] sync;
	logic level, rd, dly, rec;
	logic next_level, next_rd, next_dly, next_rec, next_drv;
	logic tap;

	// ***************************************************************
	// sampling and read flip-flops
	// ***************************************************************
	// tap mux sits ahead of the synchroniser so one chain serves both
	assign tap = i_use_alt ? i_head_alt : i_head;

	// filtered level moves only when stages two and three agree
	always_comb begin
		next_level = level;
		if (sync[1] == sync[2]) begin
			next_level = sync[2];
		end
		next_rd = rd;
		next_dly = dly;
		if (i_mid_stb) begin
			next_rd = level;
			next_dly = rd;
		end
	end

	// ***************************************************************
	// record flip-flop and winding drive
	// ***************************************************************
	always_comb begin
		next_rec = rec;
		if (i_bit_stb) begin
			next_rec = i_rec_bit;
		end else if (i_mid_stb) begin
			next_rec = ~rec;
		end
		// drive stops at the end of the record window, before next cell
		next_drv = i_rec_en & i_rec_gate;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sync <= 3'h0;
			level <= 1'b0;
			rd <= 1'b0;
			dly <= 1'b0;
			rec <= 1'b0;
		end else begin
			sync <= {sync[1:0], tap};
			level <= next_level;
			rd <= next_rd;
			dly <= next_dly;
			rec <= next_rec;
		end
	end

	// outputs registered: one winding or the other, never both
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_head_a <= 1'b0;
			o_head_b <= 1'b0;
		end else begin
			o_head_a <= next_drv & next_rec;
			o_head_b <= next_drv & ~next_rec;
		end
	end

	assign o_early = rd;
	assign o_bit = dly;
endmodule

`default_nettype wire

// file: dpt_drum_model.sv
// drum model: clock track that runs while i_run is high, and three timing tracks
`default_nettype none
module dpt_drum_model (
	// drum motion
	input wire logic i_run,
	// head levels
	output logic o_clk_track,
	output logic [2:0] o_track
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// drum rotation
	// ****
	int p = 0;
	int sec = 0;
	// half bit cell of 4 us; a stopped drum freezes the clock track
	initial begin
		o_clk_track = 1'b0;
		o_track = 3'h0;
		forever begin
			#4000;
			if (i_run) begin
				o_clk_track = ~o_clk_track;
			end
		end
	end
	// tracks change at cell start, far from the mid-bit read time
	always @(negedge o_clk_track) begin
		p = (p + 1) % 32;
		if (p == 0) begin
			sec = (sec + 1) % 64;
		end
		// sector number in both fields: next-address one, then operand
		if (p == 0) begin
			o_track[0] = (sec % 8 == 0);
		end else if (p >= 7 && p < 20 && p != 13) begin
			o_track[0] = sec[(p < 14) ? p - 7 : p - 14];
		end else begin
			o_track[0] = 1'b0;
		end
		o_track[1] = p <= 12;
		o_track[2] = !((p >= 7 && p <= 12) || (p >= 14 && p <= 19));
	end
endmodule
`default_nettype wire

// file: dpt_drum_timing_props.sv
// checker for bit strobes, line flops and word timing
`default_nettype none
module dpt_drum_timing_props #(
	parameter int LINES = dpt_pkg::NLINES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// watched outputs
	input wire logic o_clock_toggle,
	input wire logic o_bit_strobe,
	input wire logic o_true_phase_strobe,
	input wire logic o_false_phase_late_strobe,
	input wire logic o_true_phase_late_strobe,
	input wire logic o_record_window_strobe,
	input wire logic [dpt_pkg::NTIMING-1:0] o_timing,
	input wire logic [LINES-1:0] o_line_early,
	input wire logic [LINES-1:0] o_line_bit,
	input wire logic [LINES-1:0] o_line_head_a,
	input wire logic [LINES-1:0] o_line_head_b
);
	import dpt_pkg::*;
	// ****
	// properties
	// ****
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// window holds its full width, then drops
	sequence win_hold;
		o_record_window_strobe throughout (##19 1'b1);
	endsequence
	sequence win_end;
		win_hold ##1 !o_record_window_strobe;
	endsequence
	true_late_a: assert property (
		o_true_phase_strobe |-> ##30 o_true_phase_late_strobe)
		else $error("late true strobe misplaced");
	false_late_a: assert property (
		o_bit_strobe |-> ##30 o_false_phase_late_strobe)
		else $error("late false strobe misplaced");
	rise_strobe_a: assert property (
		$rose(o_clock_toggle) |-> o_true_phase_strobe)
		else $error("no true strobe at toggle rise");
	fall_strobe_a: assert property (
		$fell(o_clock_toggle) |-> o_bit_strobe)
		else $error("no bit strobe at toggle fall");
	win_width_a: assert property (
		$rose(o_record_window_strobe) |-> win_end)
		else $error("record window width wrong");
	win_place_a: assert property (
		o_true_phase_strobe |-> ##10 $rose(o_record_window_strobe))
		else $error("record window misplaced");
	heads_excl_a: assert property (
		(o_line_head_a & o_line_head_b) == '0)
		else $error("both windings driven");
	heads_quiet_a: assert property (
		$fell(o_record_window_strobe) |->
		##2 (o_line_head_a | o_line_head_b) == '0)
		else $error("drive after record window");
	read_delay_a: assert property (
		o_true_phase_strobe |=> o_line_bit == $past(o_line_early))
		else $error("delayed flop lost early value");
	timing_upd_a: assert property (
		$changed(o_timing) |-> $past(o_true_phase_late_strobe))
		else $error("timing changed off strobe");
	eighth_sign_a: assert property (
		o_timing[7] |-> o_timing[5])
		else $error("eighth pulse without sign time");
endmodule
bind dpt_drum_timing dpt_drum_timing_props #(.LINES(LINES)) u_props (
	.i_clk_sys, .i_rst_n, .o_clock_toggle, .o_bit_strobe,
	.o_true_phase_strobe, .o_false_phase_late_strobe,
	.o_true_phase_late_strobe, .o_record_window_strobe, .o_timing,
	.o_line_early, .o_line_bit, .o_line_head_a, .o_line_head_b
);
`default_nettype wire

// file: dpt_drum_timing_tb.sv
// testbench for the drum timing block
`default_nettype none
module dpt_drum_timing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// signals, design and drum
	// ****
	logic i_clk_sys, i_rst_n, run, mdv, lng, ctk, tog, bs, tps, fls, tls;
	logic rws, sm;
	logic [2:0] trk;
	logic [4:0] head, alt, wsel, wdat, ren, bc, early, lbit, ha, hb, stb;
	logic [5:0] sc, snum, req;
	logic [7:0] tim;
	int fail_count, samples_checked;
	assign stb = {tim[7], fls, tls, bs, tps};
	dpt_drum_timing #(.LINES(5)) DUT (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_clk_track(ctk), .i_track_head(trk),
		.i_line_head(head), .i_line_head_alt(alt), .i_mul_div(mdv),
		.i_lengthen(lng), .i_line_wr_sel(wsel), .i_line_wr_data(wdat),
		.i_line_rec_en(ren), .i_req_sector(req), .o_clock_toggle(tog),
		.o_bit_strobe(bs), .o_true_phase_strobe(tps),
		.o_false_phase_late_strobe(fls), .o_true_phase_late_strobe(tls),
		.o_record_window_strobe(rws), .o_timing(tim), .o_bit_count(bc),
		.o_sector_count(sc), .o_sector_num(snum), .o_sector_match(sm),
		.o_line_early(early), .o_line_bit(lbit), .o_line_head_a(ha),
		.o_line_head_b(hb));
	dpt_drum_model drum (.i_run(run), .o_clk_track(ctk), .o_track(trk));
	// ****
	// shared tasks
	// ****
	task check(input string nm, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// bound covers eight word periods, the longest wait
	task wait_stb(input int k, output int n);
		n = 0;
		do begin
			@(negedge i_clk_sys);
			n++;
		end while (stb[k] !== 1'b1 && n < 25000);
		if (n >= 25000) begin
			fail_count++;
			$display("Error strobe %0d expected 1 seen 0", k);
			report_and_stop();
		end
	endtask
	// ****
	// scenarios
	// ****
	task t_strobe;
		int n;
		wait_stb(0, n);
		wait_stb(2, n);
		check("true late gap", 8'(n), 8'h1e);
		wait_stb(1, n);
		check("half cell", 8'(n + 30), 8'h28);
		wait_stb(3, n);
		check("false late gap", 8'(n), 8'h1e);
		$display("strobe test done");
	endtask
	// skip the toggle already in the synchroniser when the drum stops
	task t_stop;
		int c;
		c = 0;
		run = 1'b0;
		repeat (10) @(negedge i_clk_sys);
		repeat (200) begin
			@(negedge i_clk_sys);
			if (bs || tps) c++;
		end
		check("stopped strobes", 8'(c), 8'h00);
		run = 1'b1;
		$display("stop test done");
	endtask
	task t_read;
		logic [4:0] e, pe;
		int n;
		for (int i = 0; i < 4; i++) begin
			wait_stb(1, n);
			head = 5'h15 ^ {5{i[0]}};
			alt = ~head;
			mdv = i[1];
			lng = i[0];
			e = head;
			if (i[1]) e[0] = alt[0];
			if (i[0]) e[1] = alt[1];
			wait_stb(0, n);
			@(negedge i_clk_sys);
			check("early lines", early[4:2], e[4:2]);
			check("command line", early[2], e[2]);
			check("fast line", early[4], e[4]);
			check("upper tap", early[0], e[0]);
			check("lower tap", early[1], e[1]);
			if (i > 0) check("delayed", lbit, pe);
			pe = e;
		end
		$display("read test done");
	endtask
	task t_record;
		logic [4:0] a0, b0;
		int n;
		wait_stb(0, n);
		wsel = 5'h1f;
		ren = 5'h1f;
		for (int i = 0; i < 2; i++) begin
			wdat = 5'h0d ^ {5{i[0]}};
			wait_stb(1, n);
			repeat (2) @(negedge i_clk_sys);
			check("winding split", ha, {3'h0, ~hb});
			if (i == 0) a0 = ha;
			else check("winding choice", ha, {3'h0, ~a0});
			b0 = hb;
			wait_stb(0, n);
			repeat (2) @(negedge i_clk_sys);
			check("mid reversal", ha, b0);
		end
		// hold the read level so both line flops settle before looking
		wsel = 5'h00;
		head = 5'h0d;
		mdv = 1'b0;
		lng = 1'b0;
		repeat (3) wait_stb(1, n);
		repeat (2) @(negedge i_clk_sys);
		check("recirculate", ha, a0);
		ren = 5'h00;
		wait_stb(1, n);
		repeat (2) @(negedge i_clk_sys);
		check("drive off", ha | hb, 8'h00);
		$display("record test done");
	endtask
	task t_word;
		int n, bits, signs, p;
		logic [7:0] e;
		bits = 0;
		signs = 0;
		wait_stb(4, n);
		do begin
			wait_stb(2, n);
			@(negedge i_clk_sys);
			bits++;
			p = bits % 32;
			if (tim[5] === 1'b1) signs++;
			// expected field marks for this bit of the drum word
			e = {1'b0, p >= 7 && p <= 12, p == 0, p >= 14 && p <= 19,
				p == 0, p >= 1 && p <= 5, p <= 6, p == 13 || p >= 20};
			check("bit count", bc, 8'(p));
			check("next address", tim[1], e[1]);
			check("sector fields", {tim[6], tim[4]}, {e[6], e[4]});
			check("word decodes", tim & 8'h2d, e & 8'h2d);
		end while (tim[7] !== 1'b1 && bits < 300);
		check("bits per group", 8'(bits / 8), 8'h20);
		check("signs per group", 8'(signs), 8'h08);
		check("sector group", sc[2:0], 8'h00);
		// next-address sector field latches after bit 13
		req = 6'(drum.sec);
		repeat (13) wait_stb(2, n);
		@(negedge i_clk_sys);
		check("sector number", snum, 8'(drum.sec));
		check("sector match", sm, 8'h01);
		// operand sector field latches after bit 20
		req = ~req;
		repeat (7) wait_stb(2, n);
		@(negedge i_clk_sys);
		check("sector mismatch", sm, 8'h00);
		$display("word test done");
	endtask
	// ****
	// clock and main sequence
	// ****
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		fail_count = 0;
		samples_checked = 0;
		{i_rst_n, mdv, lng} = 3'h0;
		run = 1'b1;
		{head, alt, wsel, wdat, ren} = 25'h0;
		req = 6'h00;
		repeat (10) @(negedge i_clk_sys);
		check("reset count", bc, 8'h00);
		i_rst_n = 1'b1;
		t_strobe();
		t_read();
		t_record();
		// drive enabled so the reset check can see the heads cleared
		ren = 5'h1f;
		i_rst_n = 1'b0;
		repeat (4) @(negedge i_clk_sys);
		check("second reset", ha | hb, 8'h00);
		i_rst_n = 1'b1;
		t_stop();
		t_strobe();
		t_word();
		report_and_stop();
	end
endmodule
`default_nettype wire
